// ===== rtl/ascl_map.svh
// ascl_map.svh: offsets, preload values and the strap code space of the
// strap configuration loader. definitions only, included by bare name.
`ifndef ASCL_MAP_SVH
`define ASCL_MAP_SVH

// register offsets on the host register port
`define ASCL_OFS_CFG_A      8'h12
`define ASCL_OFS_CFG_B      8'h14
`define ASCL_OFS_POWER_CFG  8'h29

// preload values per strap class
`define ASCL_VAL_OFF        8'h00
`define ASCL_VAL_ALL_PORTS  8'hFF
`define ASCL_VAL_LOW_POWER  8'h00
`define ASCL_VAL_HIGH_POWER 8'h33

// codes reported by the strap resistance classifier
`define ASCL_CODE_OPEN      2'h0
`define ASCL_CODE_124K      2'h1
`define ASCL_CODE_62K       2'h2

`endif

// ===== rtl/ascl_pkg.sv
// ascl_pkg.sv: types shared by the strap configuration loader.
// assumes nothing beyond a systemverilog compiler.
`default_nettype none

package ascl_pkg;
    typedef logic [7:0] ascl_byte_t;
    typedef logic [7:0] ascl_addr_t;
    typedef logic [1:0] ascl_code_t;
    // autonomous mode selected by the strap
    typedef enum logic [1:0] {
        ASCL_MODE_DISABLED,
        ASCL_MODE_LOW,
        ASCL_MODE_HIGH
    } ascl_mode_e;
    // loader sequence
    typedef enum logic [1:0] {
        ASCL_ST_WAIT,
        ASCL_ST_LOAD,
        ASCL_ST_RUN
    } ascl_state_e;
endpackage

`default_nettype wire

// ===== rtl/ascl_cfg_reg.sv
// ascl_cfg_reg.sv: one 8-bit configuration register with a preload path
// and a host write path. assumes a synchronous active-high clear.
`default_nettype none

`include "ascl_map.svh"

module ascl_cfg_reg (
    input  wire logic                 core_clk, // device clock
    input  wire logic                 clr,      // force to off value
    input  wire logic                 load,     // strap preload strobe
    input  wire ascl_pkg::ascl_byte_t load_val, // strap preload value
    input  wire logic                 wr,       // host write strobe
    input  wire ascl_pkg::ascl_byte_t wr_val,   // host write data
    output var  ascl_pkg::ascl_byte_t val_q     // stored value
);
    import ascl_pkg::*;

    ascl_byte_t val_d;

    // clear beats preload beats host write: reset must leave ports off
    always_comb begin
        val_d = val_q;
        if (clr) begin
            val_d = `ASCL_VAL_OFF;
        end else if (load) begin
            val_d = load_val;
        end else if (wr) begin
            val_d = wr_val;
        end
    end

    always_ff @(posedge core_clk) begin
        val_q <= val_d;
    end
endmodule

`default_nettype wire

// ===== rtl/ascl_loader.sv
// ascl_loader.sv: power-up strap configuration loader. classifies the
// strap code once after power-on and preloads three config registers.
// assumes the analog classifier gives a code with a valid strobe, and a
// host register port already decoded from the serial interface.
//
// Operation
// - classify strap at power-up, preload three registers
// - autonomous mode starts from preloaded values; host writes may change them
// - one power level shared by all ports
// - open strap: disabled, all registers zero
// - 124k strap: low power, FF FF 00
// - strap sampled once per power cycle
// - hardware reset turns every port off
`default_nettype none

`include "ascl_map.svh"

module ascl_loader (
    input  wire logic                 core_clk,    // device clock
    input  wire logic                 srst,        // power-on reset, high
    input  wire logic                 hw_rst,      // hardware reset pin
    input  wire ascl_pkg::ascl_code_t strap_code,  // classifier result
    input  wire logic                 strap_valid, // classifier done
    input  wire logic                 host_wr,     // host write strobe
    input  wire logic                 host_rd,     // host read strobe
    input  wire ascl_pkg::ascl_addr_t host_addr,   // host register offset
    input  wire ascl_pkg::ascl_byte_t host_wdata,  // host write data
    output var  ascl_pkg::ascl_byte_t host_rdata_q,  // host read data
    output var  logic                 host_rvalid_q, // read data valid
    output var  ascl_pkg::ascl_byte_t cfg_a_q,       // config register a
    output var  ascl_pkg::ascl_byte_t cfg_b_q,       // config register b
    output var  ascl_pkg::ascl_byte_t power_cfg_q,   // power level config
    output var  logic                 auto_en_q,     // autonomous mode on
    output var  ascl_pkg::ascl_mode_e mode_q,        // selected mode
    output var  logic                 loaded_q       // preload complete
);
    import ascl_pkg::*;

    ascl_state_e state_q, state_d;
    ascl_mode_e  mode_d;
    logic        auto_en_d;
    logic        loaded_d;
    logic        load;
    ascl_byte_t  ld_a, ld_b, ld_p;
    logic        wr_a, wr_b, wr_p;
    ascl_byte_t  rdata_d;
    logic        rvalid_d;

    // sequence: wait for classifier, preload once, then run. no way back to
    // wait except srst, so a strap change while powered is ignored.
    always_comb begin
        state_d   = state_q;
        mode_d    = mode_q;
        auto_en_d = auto_en_q;
        loaded_d  = loaded_q;
        load      = 1'b0;
        case (state_q)
            ASCL_ST_WAIT: begin
                if (strap_valid) begin
                    state_d = ASCL_ST_LOAD;
                    case (strap_code)
                        `ASCL_CODE_124K: mode_d = ASCL_MODE_LOW;
                        `ASCL_CODE_62K:  mode_d = ASCL_MODE_HIGH;
                        default:         mode_d = ASCL_MODE_DISABLED;
                    endcase
                end
            end
            ASCL_ST_LOAD: begin
                load      = 1'b1;
                auto_en_d = (mode_q != ASCL_MODE_DISABLED);
                loaded_d  = 1'b1;
                state_d   = ASCL_ST_RUN;
            end
            ASCL_ST_RUN: begin
                state_d = ASCL_ST_RUN;
            end
            default: begin
                state_d = ASCL_ST_WAIT;
            end
        endcase
        // hardware reset forces ports off but keeps the strap result
        if (hw_rst) begin
            auto_en_d = 1'b0;
        end
        if (srst) begin
            state_d   = ASCL_ST_WAIT;
            mode_d    = ASCL_MODE_DISABLED;
            auto_en_d = 1'b0;
            loaded_d  = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        state_q   <= state_d;
        mode_q    <= mode_d;
        auto_en_q <= auto_en_d;
        loaded_q  <= loaded_d;
    end

    // preload values; one power byte for all ports, no per-port choice
    always_comb begin
        case (mode_q)
            ASCL_MODE_LOW: begin
                ld_a = `ASCL_VAL_ALL_PORTS;
                ld_b = `ASCL_VAL_ALL_PORTS;
                ld_p = `ASCL_VAL_LOW_POWER;
            end
            ASCL_MODE_HIGH: begin
                ld_a = `ASCL_VAL_ALL_PORTS;
                ld_b = `ASCL_VAL_ALL_PORTS;
                ld_p = `ASCL_VAL_HIGH_POWER;
            end
            default: begin
                ld_a = `ASCL_VAL_OFF;
                ld_b = `ASCL_VAL_OFF;
                ld_p = `ASCL_VAL_OFF;
            end
        endcase
    end

    // host writes decode; ignored until preload is done so it cannot race
    always_comb begin
        wr_a = host_wr && loaded_q && (host_addr == `ASCL_OFS_CFG_A);
        wr_b = host_wr && loaded_q && (host_addr == `ASCL_OFS_CFG_B);
        wr_p = host_wr && loaded_q && (host_addr == `ASCL_OFS_POWER_CFG);
    end

    ascl_cfg_reg u_cfg_a (
        .core_clk (core_clk),
        .clr      (srst | hw_rst),
        .load     (load),
        .load_val (ld_a),
        .wr       (wr_a),
        .wr_val   (host_wdata),
        .val_q    (cfg_a_q)
    );

    ascl_cfg_reg u_cfg_b (
        .core_clk (core_clk),
        .clr      (srst | hw_rst),
        .load     (load),
        .load_val (ld_b),
        .wr       (wr_b),
        .wr_val   (host_wdata),
        .val_q    (cfg_b_q)
    );

    ascl_cfg_reg u_power (
        .core_clk (core_clk),
        .clr      (srst | hw_rst),
        .load     (load),
        .load_val (ld_p),
        .wr       (wr_p),
        .wr_val   (host_wdata),
        .val_q    (power_cfg_q)
    );

    // read port: one-cycle latency, unmapped offsets read zero
    always_comb begin
        rvalid_d = host_rd && !srst;
        case (host_addr)
            `ASCL_OFS_CFG_A:     rdata_d = cfg_a_q;
            `ASCL_OFS_CFG_B:     rdata_d = cfg_b_q;
            `ASCL_OFS_POWER_CFG: rdata_d = power_cfg_q;
            default:             rdata_d = `ASCL_VAL_OFF;
        endcase
        if (!host_rd || srst) begin
            rdata_d = `ASCL_VAL_OFF;
        end
    end

    always_ff @(posedge core_clk) begin
        host_rdata_q  <= rdata_d;
        host_rvalid_q <= rvalid_d;
    end

    // checks
    a_strap_low_vals: assert property (@(posedge core_clk) disable iff (srst)
        state_q == ASCL_ST_LOAD && mode_q == ASCL_MODE_LOW && !hw_rst
        |=> cfg_a_q == 8'hFF && cfg_b_q == 8'hFF && power_cfg_q == 8'h00)
        else $error("low power preload wrong");
    a_strap_high_vals: assert property (@(posedge core_clk) disable iff (srst)
        state_q == ASCL_ST_LOAD && mode_q == ASCL_MODE_HIGH && !hw_rst
        |=> cfg_a_q == 8'hFF && cfg_b_q == 8'hFF && power_cfg_q == 8'h33)
        else $error("high power preload wrong");
    a_strap_open_vals: assert property (@(posedge core_clk) disable iff (srst)
        state_q == ASCL_ST_LOAD && mode_q == ASCL_MODE_DISABLED
        |=> cfg_a_q == 8'h00 && cfg_b_q == 8'h00 && power_cfg_q == 8'h00
        && !auto_en_q)
        else $error("open strap preload wrong");
    a_unknown_code: assert property (@(posedge core_clk) disable iff (srst)
        state_q == ASCL_ST_WAIT && strap_valid && strap_code == 2'h3
        |=> mode_q == ASCL_MODE_DISABLED)
        else $error("unknown strap code not open");
    a_strap_once: assert property (@(posedge core_clk) disable iff (srst)
        loaded_q |=> $stable(mode_q) && loaded_q)
        else $error("strap resampled while powered");
    a_load_seq: assert property (@(posedge core_clk) disable iff (srst)
        state_q == ASCL_ST_WAIT && strap_valid ##1 !hw_rst
        |=> loaded_q)
        else $error("preload not done in two cycles");
    a_hw_reset_off: assert property (@(posedge core_clk) disable iff (srst)
        hw_rst |=> cfg_a_q == 8'h00 && cfg_b_q == 8'h00 && !auto_en_q)
        else $error("hardware reset left ports on");
    a_auto_needs_mode: assert property (@(posedge core_clk) disable iff (srst)
        auto_en_q |-> mode_q != ASCL_MODE_DISABLED && loaded_q)
        else $error("autonomous mode without strap");
    a_power_uniform: assert property (@(posedge core_clk) disable iff (srst)
        $rose(loaded_q) && !$past(hw_rst) |-> power_cfg_q ==
        (mode_q == ASCL_MODE_HIGH ? 8'h33 : 8'h00))
        else $error("power level preload wrong");
    c_low: cover property (@(posedge core_clk)
        $rose(auto_en_q) && mode_q == ASCL_MODE_LOW);
    c_high: cover property (@(posedge core_clk)
        $rose(auto_en_q) && mode_q == ASCL_MODE_HIGH);
    c_host_wr: cover property (@(posedge core_clk) wr_p);
    c_hw_rst: cover property (@(posedge core_clk) loaded_q && hw_rst);
endmodule

`default_nettype wire

// ===== bench/ascl_host_model.sv
// ascl_host_model.sv: host master on the plain register port.
// assumes tb clock; drives only at falling edges, one strobe at a time.
`default_nettype none

module ascl_host_model (
    input  wire logic                 core_clk,      // device clock
    output logic                      host_wr,       // write strobe
    output logic                      host_rd,       // read strobe
    output ascl_pkg::ascl_addr_t      host_addr,     // register offset
    output ascl_pkg::ascl_byte_t      host_wdata,    // write data
    input  wire ascl_pkg::ascl_byte_t host_rdata_q,  // read data
    input  wire logic                 host_rvalid_q  // read data valid
);
    timeunit 1ns;
    timeprecision 1ps;
    import ascl_pkg::*;

    // idle bus at time zero
    initial begin
        host_wr = 1'b0;
        host_rd = 1'b0;
        host_addr = 8'h00;
        host_wdata = 8'h00;
    end

    // one-cycle write; data is inverted once released so stale data shows
    task automatic wr(input ascl_addr_t a, input ascl_byte_t d);
        @(negedge core_clk);
        host_addr = a;
        host_wdata = d;
        host_wr = 1'b1;
        @(negedge core_clk);
        host_wr = 1'b0;
        host_wdata = ~d;
    endtask

    // one-cycle read; valid stands only one cycle after the strobe edge,
    // so data is taken at the first falling edge after that edge
    task automatic rd(input ascl_addr_t a, output ascl_byte_t d);
        @(negedge core_clk);
        host_addr = a;
        host_rd = 1'b1;
        @(negedge core_clk);
        d = (host_rvalid_q === 1'b1) ? host_rdata_q : 8'hXX;
        host_rd = 1'b0;
    endtask
endmodule

`default_nettype wire

// ===== bench/tb.sv
// tb.sv: self-checking bench for the strap configuration loader.
// assumes the host model as the register-port master; strap from bench.
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ascl_pkg::*;

    typedef struct packed {
        ascl_code_t c;
        ascl_byte_t a;
        ascl_byte_t p;
        logic       en;
        ascl_mode_e m;
    } ascl_row_s;

    logic       core_clk, srst, hw_rst, strap_valid, wr, rd;
    logic       rvalid, auto_en, loaded;
    ascl_code_t strap_code;
    ascl_addr_t addr;
    ascl_byte_t wdata, rdata, cfg_a, cfg_b, pwr, d;
    ascl_mode_e mode;
    int         fail_count, tests_run;
    // code 3 is outside the defined straps and must read as open
    ascl_row_s  rows [4] = '{
        '{2'h0, 8'h00, 8'h00, 1'b0, ASCL_MODE_DISABLED},
        '{2'h1, 8'hFF, 8'h00, 1'b1, ASCL_MODE_LOW},
        '{2'h2, 8'hFF, 8'h33, 1'b1, ASCL_MODE_HIGH},
        '{2'h3, 8'h00, 8'h00, 1'b0, ASCL_MODE_DISABLED}};

    ascl_loader dut_u (.core_clk(core_clk), .srst(srst), .hw_rst(hw_rst),
        .strap_code(strap_code), .strap_valid(strap_valid),
        .host_wr(wr), .host_rd(rd), .host_addr(addr), .host_wdata(wdata),
        .host_rdata_q(rdata), .host_rvalid_q(rvalid), .cfg_a_q(cfg_a),
        .cfg_b_q(cfg_b), .power_cfg_q(pwr), .auto_en_q(auto_en),
        .mode_q(mode), .loaded_q(loaded));

    ascl_host_model host_u (.core_clk(core_clk), .host_wr(wr),
        .host_rd(rd), .host_addr(addr), .host_wdata(wdata),
        .host_rdata_q(rdata), .host_rvalid_q(rvalid));

    // 200 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic check(input string n, input logic [7:0] s,
                         input logic [7:0] e);
        tests_run++;
        if (s !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // power-on reset held four cycles, then one idle cycle
    task automatic reset_only;
        srst = 1'b1;
        repeat (4) @(negedge core_clk);
        srst = 1'b0;
        @(negedge core_clk);
    endtask

    // classifier done pulse; loaded one rising edge after it is taken
    task automatic strap(input ascl_code_t c);
        strap_code = c;
        strap_valid = 1'b1;
        @(negedge core_clk);
        strap_valid = 1'b0;
        repeat (2) @(negedge core_clk);
    endtask

    // watchdog: the whole run needs well under 400 cycles
    initial begin
        repeat (4000) @(posedge core_clk);
        fail_count++;
        give_verdict();
    end

    // row loop for each strap class, then hand-written cases
    initial begin
        fail_count = 0;
        tests_run = 0;
        srst = 1'b1;
        hw_rst = 1'b0;
        strap_code = 2'h0;
        strap_valid = 1'b0;
        for (int i = 0; i < 4; i++) begin
            reset_only();
            strap(rows[i].c);
            check("cfg_a", cfg_a, rows[i].a);
            check("cfg_b", cfg_b, rows[i].a);
            check("power_cfg", pwr, rows[i].p);
            check("auto_en", {7'h0, auto_en}, {7'h0, rows[i].en});
            check("mode", {6'h0, mode}, {6'h0, rows[i].m});
            check("loaded", {7'h0, loaded}, 8'h01);
            host_u.rd(8'h14, d);
            check("rd_cfg_b", d, rows[i].a);
            $display("strap row %0d done", i);
        end
        // write before preload is ignored, preload still lands
        reset_only();
        host_u.wr(8'h12, 8'h5A);
        check("early_wr_held", cfg_a, 8'h00);
        strap(2'h1);
        check("early_wr", cfg_a, 8'hFF);
        // strap change while powered must not reload
        strap(2'h2);
        check("late_strap", pwr, 8'h00);
        check("late_mode", {6'h0, mode}, {6'h0, ASCL_MODE_LOW});
        $display("strap resample test done");
        // host write, read back, unmapped offset reads zero
        host_u.wr(8'h29, 8'h5A);
        host_u.rd(8'h29, d);
        check("host_wr", d, 8'h5A);
        host_u.wr(8'h30, 8'hC3);
        host_u.rd(8'h30, d);
        check("unmapped", d, 8'h00);
        $display("host access test done");
        // hardware reset abandons host settings and turns ports off
        hw_rst = 1'b1;
        @(negedge core_clk);
        hw_rst = 1'b0;
        @(negedge core_clk);
        check("hw_cfg_a", cfg_a, 8'h00);
        check("hw_power", pwr, 8'h00);
        check("hw_auto", {7'h0, auto_en}, 8'h00);
        $display("hardware reset test done");
        // power-on reset mid-run clears all, the next strap is taken again
        reset_only();
        check("rst_cfg_a", cfg_a, 8'h00);
        check("rst_loaded", {7'h0, loaded}, 8'h00);
        strap(2'h2);
        check("reload_power", pwr, 8'h33);
        check("reload_auto", {7'h0, auto_en}, 8'h01);
        $display("power cycle test done");
        give_verdict();
    end
endmodule

`default_nettype wire
